// >>> logic/aclr_receiver.sv
// Command line receiver: line buffer, editing codes, reply generation
`timescale 1ns/1ps
module aclr_receiver
  import aclr_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] baud_sel,
  input wire logic rxd,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  input wire logic line_ack,
  input wire logic syntax_err,
  input wire logic word_signed,
  input wire logic tx_ready,
  output logic [7:0] rd_char,
  output logic line_valid,
  output logic [$clog2(DEPTH):0] line_len,
  output logic value_signed,
  output aclr_txchar_s tx_out,
  output logic busy
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] LEN_FULL = (AW+1)'(DEPTH);
  localparam int MSG_LEN = 20;
  localparam logic [4:0] M_NULL = 5'h00;

  typedef enum {ACLR_IDLE, ACLR_HOLD, ACLR_SEND} aclr_st_e;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] fold_case(input logic [7:0] c);
    if (c >= CH_LOWER_A && c <= CH_LOWER_Z) begin
      return c & ~CASE_BIT;
    end
    return c;
  endfunction

  // Reply text left aligned in a fixed field; msg_len gives its length
  function automatic logic [7:0] msg_char(input aclr_reply_e k, input logic syn, input logic [4:0] i);
    logic [8*MSG_LEN-1:0] s;
    s = '0;
    if (syn) begin
      s = {"Syntax Error", CH_CR, CH_LF, 48'h0};
    end else begin
      case (k)
        ACLR_RPL_COMERR: s = {CH_CR, CH_LF, "COM Error", CH_CR, CH_LF, 56'h0};
        ACLR_RPL_OVFL: s = {CH_CR, CH_LF, "Buffer Overflow", CH_CR, CH_LF, 8'h0};
        default: s = {CH_CR, CH_LF, 144'h0};
      endcase
    end
    return s[8*(MSG_LEN-1-int'(i)) +: 8];
  endfunction

  function automatic logic [4:0] msg_len(input aclr_reply_e k, input logic syn);
    if (syn) begin
      return 5'h0E;
    end
    case (k)
      ACLR_RPL_COMERR: return 5'h0D;
      ACLR_RPL_OVFL: return 5'h13;
      default: return 5'h02;
    endcase
  endfunction

  // ==========================================================
  // Receiver
  aclr_rxchar_s rx;

  aclr_uart_rx u_rx (
    .mclk(mclk),
    .nrst(nrst),
    .baud_sel(baud_sel),
    .rxd(rxd),
    .rx_out(rx)
  );

  // ==========================================================
  // State
  logic [7:0] buf_mem [DEPTH];
  logic [7:0] buf_next [DEPTH];
  logic [AW:0] len_reg, len_next;
  logic ovf_reg, ovf_next;
  aclr_st_e st_reg, st_next;
  aclr_reply_e kind_reg, kind_next;
  logic syn_reg, syn_next;
  logic [4:0] pos_reg, pos_next;
  logic lv_reg, lv_next;
  logic vs_reg, vs_next;
  aclr_txchar_s tx_reg, tx_next;
  logic [7:0] rdc_reg, rdc_next;
  logic [7:0] c;

  always_comb begin
    buf_next = buf_mem;
    len_next = len_reg;
    ovf_next = ovf_reg;
    st_next = st_reg;
    kind_next = kind_reg;
    syn_next = syn_reg;
    pos_next = pos_reg;
    lv_next = lv_reg;
    vs_next = word_signed;
    tx_next = tx_reg;
    rdc_next = buf_mem[rd_idx];
    c = fold_case(rx.data);
    if (tx_reg.valid && tx_ready) begin
      tx_next.valid = 1'b0;
    end
    // Characters arriving outside idle are dropped: there is no receive buffer
    case (st_reg)
      ACLR_IDLE: begin
        if (rx.valid) begin
          if (rx.frame_err) begin
            kind_next = ACLR_RPL_COMERR;
            syn_next = 1'b0;
            pos_next = M_NULL;
            len_next = '0;
            ovf_next = 1'b0;
            st_next = ACLR_SEND;
          end else if (c == CH_SPACE) begin
            len_next = len_reg;
          end else if (c == CH_ESC) begin
            len_next = '0;
            ovf_next = 1'b0;
            kind_next = ACLR_RPL_NULL;
            syn_next = 1'b0;
            pos_next = M_NULL;
            st_next = ACLR_SEND;
          end else if (c == CH_BKSP) begin
            if (len_reg != '0) begin
              len_next = len_reg - 1'b1;
            end
          end else if (c == CH_CR) begin
            if (ovf_reg) begin
              kind_next = ACLR_RPL_OVFL;
              syn_next = 1'b0;
              pos_next = M_NULL;
              len_next = '0;
              ovf_next = 1'b0;
              st_next = ACLR_SEND;
            end else begin
              lv_next = 1'b1;
              st_next = ACLR_HOLD;
            end
          end else if (len_reg == LEN_FULL) begin
            ovf_next = 1'b1;
          end else begin
            buf_next[len_reg[AW-1:0]] = c;
            len_next = len_reg + 1'b1;
          end
        end
      end
      ACLR_HOLD: begin
        if (line_ack) begin
          lv_next = 1'b0;
          syn_next = syntax_err;
          kind_next = ACLR_RPL_NULL;
          pos_next = M_NULL;
          len_next = '0;
          st_next = ACLR_SEND;
        end
      end
      // The closing LF may still wait on tx_ready after busy drops
      ACLR_SEND: begin
        if (!tx_reg.valid || tx_ready) begin
          tx_next.valid = 1'b1;
          tx_next.data = msg_char(kind_reg, syn_reg, pos_reg);
          pos_next = pos_reg + 5'h01;
          if (pos_reg + 5'h01 == msg_len(kind_reg, syn_reg)) begin
            st_next = ACLR_IDLE;
          end
        end
      end
      default: st_next = ACLR_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        buf_mem[i] <= '0;
      end
      len_reg <= '0;
      ovf_reg <= 1'b0;
      st_reg <= ACLR_IDLE;
      kind_reg <= ACLR_RPL_NONE;
      syn_reg <= 1'b0;
      pos_reg <= '0;
      lv_reg <= 1'b0;
      vs_reg <= 1'b0;
      tx_reg <= '0;
      rdc_reg <= '0;
    end else begin
      buf_mem <= buf_next;
      len_reg <= len_next;
      ovf_reg <= ovf_next;
      st_reg <= st_next;
      kind_reg <= kind_next;
      syn_reg <= syn_next;
      pos_reg <= pos_next;
      lv_reg <= lv_next;
      vs_reg <= vs_next;
      tx_reg <= tx_next;
      rdc_reg <= rdc_next;
    end
  end

  // ==========================================================
  // Outputs
  logic busy_reg;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (st_next != ACLR_IDLE);
    end
  end

  assign rd_char = rdc_reg;
  assign line_valid = lv_reg;
  assign line_len = len_reg;
  assign value_signed = vs_reg;
  assign tx_out = tx_reg;
  assign busy = busy_reg;

  // ==========================================================
  // Checks
  a_space_not_stored: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_IDLE && rx.valid && !rx.frame_err && rx.data == CH_SPACE) |=> $stable(len_reg))
    else $error("space changed buffer length");
  a_bksp_removes: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_IDLE && rx.valid && !rx.frame_err && rx.data == CH_BKSP && len_reg != '0)
    |=> len_reg == $past(len_reg) - 1'b1)
    else $error("backspace did not remove a character");
  a_bksp_empty: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_IDLE && rx.valid && !rx.frame_err && rx.data == CH_BKSP && len_reg == '0)
    |=> len_reg == '0 && st_reg == ACLR_IDLE)
    else $error("backspace on empty buffer had effect");
  a_esc_clears: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_IDLE && rx.valid && !rx.frame_err && rx.data == CH_ESC) |=> len_reg == '0 && st_reg == ACLR_SEND)
    else $error("escape did not clear buffer");
  a_esc_reply: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_IDLE && rx.valid && !rx.frame_err && rx.data == CH_ESC) |=> kind_reg == ACLR_RPL_NULL && !syn_reg)
    else $error("escape reply is not the null reply");
  a_cr_handoff: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_IDLE && rx.valid && !rx.frame_err && rx.data == CH_CR && !ovf_reg) |=> line_valid)
    else $error("carriage return did not hand off line");
  a_case_fold: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_IDLE && rx.valid && !rx.frame_err && rx.data == CH_LOWER_A && len_reg < LEN_FULL)
    |=> buf_mem[$past(len_reg[AW-1:0])] == (CH_LOWER_A & ~CASE_BIT))
    else $error("lower case not folded");
  a_comerr_reply: assert property (@(posedge mclk) disable iff (!nrst)
    (rx.valid && rx.frame_err && st_reg == ACLR_IDLE) |=> kind_reg == ACLR_RPL_COMERR && st_reg == ACLR_SEND)
    else $error("framing fault did not start COM error reply");
  a_lf_after_cr: assert property (@(posedge mclk) disable iff (!nrst)
    (tx_reg.valid && tx_ready && tx_reg.data == CH_CR && st_reg == ACLR_SEND) |=> tx_reg.data == CH_LF)
    else $error("CR not followed by LF");
  a_lf_last: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_SEND && st_next == ACLR_IDLE) |=> tx_reg.valid && tx_reg.data == CH_LF)
    else $error("reply did not end with LF");
  a_tx_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (tx_reg.valid && !tx_ready) |=> tx_reg.valid && $stable(tx_reg.data))
    else $error("reply character dropped before it was taken");
  a_ovf_set: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_IDLE && rx.valid && !rx.frame_err && len_reg == LEN_FULL
      && rx.data >= CH_LOWER_A && rx.data <= CH_LOWER_Z) |=> ovf_reg)
    else $error("character beyond buffer did not set overflow");
  a_ovf_reply: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_IDLE && rx.valid && !rx.frame_err && rx.data == CH_CR && ovf_reg)
    |=> kind_reg == ACLR_RPL_OVFL && st_reg == ACLR_SEND && !line_valid)
    else $error("overflowed line did not start overflow reply");
  a_line_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (line_valid && !line_ack) |=> line_valid)
    else $error("line hand-off dropped before acknowledge");
  a_syn_reply: assert property (@(posedge mclk) disable iff (!nrst)
    (st_reg == ACLR_HOLD && line_ack) |=> st_reg == ACLR_SEND && syn_reg == $past(syntax_err))
    else $error("syntax flag not taken at hand-off");
  c_esc: cover property (@(posedge mclk) st_reg == ACLR_IDLE && rx.valid && rx.data == CH_ESC);
  c_line: cover property (@(posedge mclk) line_valid && line_ack);
  c_ovf: cover property (@(posedge mclk) ovf_reg && st_next == ACLR_SEND);
  c_err: cover property (@(posedge mclk) rx.valid && rx.frame_err);
  c_syn: cover property (@(posedge mclk) st_reg == ACLR_HOLD && line_ack && syntax_err);

endmodule

// >>> logic/aclr_pkg.sv
// Package for the ASCII command line receiver: codes, timing, carriers
package aclr_pkg;

  // ==========================================================
  // Character codes
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_BKSP = 8'h80;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_LOWER_A = 8'h61;
  localparam logic [7:0] CH_LOWER_Z = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // ==========================================================
  // Frame and baud
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int CLK_HZ = 25000000;
  localparam int BAUD_0 = 9600;
  localparam int BAUD_1 = 19200;
  localparam int BAUD_2 = 38400;
  localparam int BAUD_3 = 56700;
  localparam int OVS = 16;
  localparam logic [15:0] DIV_0 = 16'(CLK_HZ / (BAUD_0 * OVS));
  localparam logic [15:0] DIV_1 = 16'(CLK_HZ / (BAUD_1 * OVS));
  localparam logic [15:0] DIV_2 = 16'(CLK_HZ / (BAUD_2 * OVS));
  localparam logic [15:0] DIV_3 = 16'(CLK_HZ / (BAUD_3 * OVS));
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] BIT_LAST = 4'h7;

  // ==========================================================
  // Reply kinds and carriers
  typedef enum logic [2:0] {
    ACLR_RPL_NONE, ACLR_RPL_NULL, ACLR_RPL_COMERR, ACLR_RPL_OVFL
  } aclr_reply_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic frame_err;
  } aclr_rxchar_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } aclr_txchar_s;

endpackage

// >>> logic/aclr_uart_rx.sv
// Serial receiver: 8 data bits, no parity, 1 stop bit, selectable baud
`timescale 1ns/1ps
module aclr_uart_rx
  import aclr_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] baud_sel,
  input wire logic rxd,
  output aclr_rxchar_s rx_out
);

  typedef enum {ACLR_RX_IDLE, ACLR_RX_START, ACLR_RX_DATA, ACLR_RX_STOP} aclr_rxst_e;

  aclr_rxst_e st_reg, st_next;
  logic [15:0] div_reg, div_next;
  logic [3:0] ovs_reg, ovs_next;
  logic [3:0] bit_reg, bit_next;
  logic line_reg, line_next;
  logic [7:0] sh_reg, sh_next;
  aclr_rxchar_s out_reg, out_next;
  logic tick;
  logic [15:0] div_top;

  // ==========================================================
  // Oversampling tick divider
  always_comb begin
    case (baud_sel)
      2'h0: div_top = DIV_0;
      2'h1: div_top = DIV_1;
      2'h2: div_top = DIV_2;
      default: div_top = DIV_3;
    endcase
  end
  assign tick = (div_reg == 16'h0000);

  always_comb begin
    div_next = tick ? div_top - 16'h0001 : div_reg - 16'h0001;
    st_next = st_reg;
    ovs_next = tick ? ovs_reg + 4'h1 : ovs_reg;
    bit_next = bit_reg;
    line_next = rxd;
    sh_next = sh_reg;
    out_next = '0;
    case (st_reg)
      ACLR_RX_IDLE: begin
        ovs_next = '0;
        // Falling edge only: a low stop bit must not restart a frame
        if (!rxd && line_reg) begin
          st_next = ACLR_RX_START;
        end
      end
      ACLR_RX_START: begin
        if (tick && ovs_reg == OVS_MID) begin
          ovs_next = '0;
          bit_next = '0;
          st_next = rxd ? ACLR_RX_IDLE : ACLR_RX_DATA;
        end
      end
      ACLR_RX_DATA: begin
        if (tick && ovs_reg == OVS_LAST) begin
          sh_next = {rxd, sh_reg[7:1]};
          bit_next = bit_reg + 4'h1;
          if (bit_reg == BIT_LAST) begin
            st_next = ACLR_RX_STOP;
          end
        end
      end
      ACLR_RX_STOP: begin
        if (tick && ovs_reg == OVS_LAST) begin
          out_next.valid = 1'b1;
          out_next.data = sh_reg;
          out_next.frame_err = !rxd;
          st_next = ACLR_RX_IDLE;
        end
      end
      default: st_next = ACLR_RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_reg <= ACLR_RX_IDLE;
      div_reg <= '0;
      ovs_reg <= '0;
      bit_reg <= '0;
      line_reg <= 1'b1;
      sh_reg <= '0;
      out_reg <= '0;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      ovs_reg <= ovs_next;
      bit_reg <= bit_next;
      line_reg <= line_next;
      sh_reg <= sh_next;
      out_reg <= out_next;
    end
  end

  assign rx_out = out_reg;

endmodule

// >>> test/aclr_host_model.sv
// Host terminal model: serial character sender and reply character sink
`timescale 1ns/1ps
module aclr_host_model
  import aclr_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] baud_sel,
  input wire logic slow,
  input aclr_txchar_s tx_out,
  output logic rxd,
  output logic tx_ready
);
  logic [7:0] rx_q[$];
  int unsigned tick = 0;

  initial begin
    rxd = 1'b1;
    tx_ready = 1'b0;
  end

  // ==========================================================
  // Bit timing follows the shared rate selection
  function automatic int bit_cycles();
    case (baud_sel)
      2'h0: return int'(DIV_0) * OVS;
      2'h1: return int'(DIV_1) * OVS;
      2'h2: return int'(DIV_2) * OVS;
      default: return int'(DIV_3) * OVS;
    endcase
  endfunction

  // ==========================================================
  // Sender: start bit, 8 data bits LSB first, one stop bit, no parity
  // Sends any single character, including CR, ESC and BKSP, with a chosen stop bit level
  task automatic send(input logic [7:0] c, input logic stop_bit);
    logic [9:0] frame;
    frame = {stop_bit, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      rxd = frame[i];
      repeat (bit_cycles() - 1) @(negedge mclk);
    end
    rxd = 1'b1;
  endtask

  // ==========================================================
  // Sink: stalls two cycles out of three when slow
  always @(negedge mclk) begin
    tick <= tick + 1;
    tx_ready <= !slow || (tick % 3 == 0);
  end

  always @(posedge mclk) begin
    if (nrst && tx_out.valid && tx_ready) begin
      rx_q.push_back(tx_out.data);
    end
  end
endmodule

// >>> test/tb_top.sv
// Testbench for the ASCII command line receiver
`timescale 1ns/1ps
module tb_top
  import aclr_pkg::*;
();
  // Small depth keeps the overflow case short
  localparam int DEPTH = 2;
  localparam int LIMIT = 95000;
  logic mclk;
  logic nrst;
  logic [1:0] baud_sel;
  logic rxd;
  logic [$clog2(DEPTH)-1:0] rd_idx;
  logic line_ack;
  logic syntax_err;
  logic word_signed;
  logic tx_ready;
  logic slow;
  logic [7:0] rd_char;
  logic line_valid;
  logic [$clog2(DEPTH):0] line_len;
  logic value_signed;
  aclr_txchar_s tx_out;
  logic busy;
  int bad_count = 0;
  int cmp_count = 0;
  int unsigned cyc = 0;

  aclr_receiver #(.DEPTH(DEPTH)) i_aclr_receiver (
    .mclk(mclk), .nrst(nrst), .baud_sel(baud_sel), .rxd(rxd), .rd_idx(rd_idx),
    .line_ack(line_ack), .syntax_err(syntax_err), .word_signed(word_signed),
    .tx_ready(tx_ready), .rd_char(rd_char), .line_valid(line_valid),
    .line_len(line_len), .value_signed(value_signed), .tx_out(tx_out), .busy(busy)
  );

  aclr_host_model i_aclr_host_model (
    .mclk(mclk), .nrst(nrst), .baud_sel(baud_sel), .slow(slow),
    .tx_out(tx_out), .rxd(rxd), .tx_ready(tx_ready)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ==========================================================
  // Helpers
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wait_level(string name, ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    check(name, 16'(sig), 16'(lvl));
  endtask

  task automatic send_str(string s);
    foreach (s[i]) i_aclr_host_model.send(s[i], 1'b1);
  endtask

  task automatic read_buf(logic [$clog2(DEPTH)-1:0] idx, logic [7:0] exp);
    rd_idx = idx;
    @(negedge mclk);
    @(negedge mclk);
    check("rd_char", 16'(rd_char), 16'(exp));
  endtask

  task automatic hand_off(logic err);
    line_ack = 1'b1;
    syntax_err = err;
    wait_level("line_valid", line_valid, 1'b0);
    @(negedge mclk);
    line_ack = 1'b0;
    syntax_err = 1'b0;
  endtask

  // Reply is optional leading CR LF, body, then CR LF
  task automatic expect_reply(string body, bit lead);
    logic [7:0] e[$];
    int n;
    if (lead) e = {CH_CR, CH_LF};
    foreach (body[i]) e.push_back(body[i]);
    e.push_back(CH_CR);
    e.push_back(CH_LF);
    repeat (4) @(negedge mclk);
    wait_level("busy", busy, 1'b0);
    // The closing LF may still wait on a slow sink after busy drops
    n = 0;
    while (tx_out.valid !== 1'b0 && n < 16) begin
      @(negedge mclk);
      n++;
    end
    check("reply_len", 16'(i_aclr_host_model.rx_q.size()), 16'(e.size()));
    foreach (e[i]) check("reply_char", 16'(i_aclr_host_model.rx_q[i]), 16'(e[i]));
    i_aclr_host_model.rx_q.delete();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_case_space();
    send_str("a B");
    i_aclr_host_model.send(CH_CR, 1'b1);
    wait_level("line_valid", line_valid, 1'b1);
    check("line_len", 16'(line_len), 16'h0002);
    read_buf(1'b0, 8'h41);
    read_buf(1'b1, 8'h42);
    hand_off(1'b0);
    expect_reply("", 1'b0);
  endtask

  task automatic t_backspace();
    slow = 1'b1;
    i_aclr_host_model.send(CH_BKSP, 1'b1);
    send_str("xy");
    i_aclr_host_model.send(CH_BKSP, 1'b1);
    i_aclr_host_model.send(CH_CR, 1'b1);
    wait_level("line_valid", line_valid, 1'b1);
    check("line_len", 16'(line_len), 16'h0001);
    read_buf(1'b0, 8'h58);
    word_signed = 1'b1;
    repeat (2) @(negedge mclk);
    check("value_signed", 16'(value_signed), 16'h0001);
    word_signed = 1'b0;
    repeat (2) @(negedge mclk);
    check("value_signed", 16'(value_signed), 16'h0000);
    hand_off(1'b1);
    expect_reply("Syntax Error", 1'b0);
    slow = 1'b0;
  endtask

  task automatic t_escape();
    send_str("q");
    i_aclr_host_model.send(CH_ESC, 1'b1);
    expect_reply("", 1'b0);
    check("line_valid", 16'(line_valid), 16'h0000);
    check("line_len", 16'(line_len), 16'h0000);
  endtask

  task automatic t_faults();
    // Stop bit held low gives a framing fault
    i_aclr_host_model.send(8'h5A, 1'b0);
    expect_reply("COM Error", 1'b1);
    check("line_len", 16'(line_len), 16'h0000);
    send_str("abc");
    i_aclr_host_model.send(CH_CR, 1'b1);
    expect_reply("Buffer Overflow", 1'b1);
  endtask

  task automatic t_baud();
    baud_sel = 2'h2;
    send_str("k");
    i_aclr_host_model.send(CH_CR, 1'b1);
    wait_level("line_valid", line_valid, 1'b1);
    read_buf(1'b0, 8'h4B);
    hand_off(1'b0);
    expect_reply("", 1'b0);
  endtask

  // ==========================================================
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      results();
    end
  end

  initial begin
    nrst = 1'b0;
    baud_sel = 2'h3;
    rd_idx = '0;
    line_ack = 1'b0;
    syntax_err = 1'b0;
    word_signed = 1'b0;
    slow = 1'b0;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    t_case_space();
    t_backspace();
    t_escape();
    t_faults();
    t_baud();
    results();
  end
endmodule
